// file: design/tic_pkg.sv
package tic_pkg;

    // ************************************************************
    // register map (byte addresses on the apb bus)
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_MASK     = 8'h08;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int         CTL_MASK3_POS = 0;
    localparam int         CTL_MASK4_POS = 1;
    localparam int         CTL_MASK5_POS = 2;
    localparam int         CTL_SEL_LSB   = 4;
    localparam int         CTL_EN_POS    = 7;
    localparam logic [2:0] SEL_RESET     = 3'h0;
    localparam logic [2:0] MASK_RESET    = 3'h0;
    localparam logic       EN_RESET      = 1'b0;
    localparam logic [3:0] NUM_RESET     = 4'h3;
    localparam logic       REQ_RESET     = 1'b0;

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int         NUM_CHAN      = 3;
    localparam logic [2:0] STAT_RESET    = 3'h0;
    localparam logic [2:0] SIRQ_MASK_RST = 3'h7;

    // ************************************************************
    // serial irq numbers, one per selector code
    // ************************************************************
    localparam logic [3:0] IRQ_OF_SEL [8] = '{4'h3, 4'h4, 4'h5, 4'ha,
                                              4'h6, 4'h7, 4'h9, 4'hb};

    // one-hot apb slave states
    typedef enum logic [1:0] {
        TIC_IDLE   = 2'b01,
        TIC_ACCESS = 2'b10
    } tic_apb_state_t;

endpackage

// file: design/tic_edge_sticky.sv
`timescale 1ns/10ps
module tic_edge_sticky #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // timer outputs
    input  wire logic [WIDTH-1:0] timer_out,
    // write-one-to-clear strobe
    input  wire logic             clr_en,
    input  wire logic [WIDTH-1:0] clr_bits,
    // sticky flags
    output logic      [WIDTH-1:0] pending
);

    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] pend_q;
    logic [WIDTH-1:0] pend_d;
    logic [WIDTH-1:0] rise;

    // rising edge on each timer output
    assign rise    = timer_out & ~prev_q;
    // set beats clear, so an edge in the clearing cycle is kept
    assign pend_d  = rise | (pend_q & ~(clr_en ? clr_bits : '0));
    assign pending = pend_q;

    // edge history and flags
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_q <= '0;
            pend_q <= '0;
        end
        else
        begin
            prev_q <= timer_out;
            pend_q <= pend_d;
        end
    end

endmodule

// file: design/tic_top.sv
`timescale 1ns/10ps
module tic_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer outputs, channels 3, 4 and 5
    input  wire logic [2:0]  timer_out,
    // serial irq request
    output logic             sirq_req,
    output logic      [3:0]  sirq_num,
    output logic      [2:0]  sirq_sel,
    // summary interrupt
    output logic             irq
);

    // ************************************************************
    // apb decode
    // ************************************************************
    logic        acc;
    logic        wr;
    logic        hit_ctl;
    logic        hit_stat;
    logic        hit_msk;
    logic        hit_any;
    logic        lane0;

    // every access completes in its first access cycle
    assign acc      = psel & penable;
    assign wr       = acc & pwrite & ~pslverr;
    assign lane0    = pstrb[0];
    assign hit_ctl  = (paddr == tic_pkg::ADDR_CONTROL);
    assign hit_stat = (paddr == tic_pkg::ADDR_STATUS);
    assign hit_msk  = (paddr == tic_pkg::ADDR_MASK);
    assign hit_any  = hit_ctl | hit_stat | hit_msk;
    assign pready   = 1'b1;
    assign pslverr  = acc & ~hit_any;

    // ************************************************************
    // control register
    // ************************************************************
    logic [2:0]  mask_q;
    logic [2:0]  mask_d;
    logic [2:0]  sel_q;
    logic [2:0]  sel_d;
    logic        en_q;
    logic        en_d;
    logic        ctl_we;
    logic [7:0]  ctl_rd;

    // only defined bits are stored; the rest are dropped
    assign ctl_we = wr & hit_ctl & lane0;
    assign mask_d = ctl_we ? pwdata[tic_pkg::CTL_MASK5_POS:tic_pkg::CTL_MASK3_POS]
                           : mask_q;
    assign sel_d  = ctl_we ? pwdata[tic_pkg::CTL_SEL_LSB +: 3] : sel_q;
    assign en_d   = ctl_we ? pwdata[tic_pkg::CTL_EN_POS] : en_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_q <= tic_pkg::MASK_RESET;
            sel_q  <= tic_pkg::SEL_RESET;
            en_q   <= tic_pkg::EN_RESET;
        end
        else
        begin
            mask_q <= mask_d;
            sel_q  <= sel_d;
            en_q   <= en_d;
        end
    end

    // bit 3 is reserved and reads zero
    assign ctl_rd = {en_q, sel_q, 1'b0, mask_q};

    // ************************************************************
    // status flags
    // ************************************************************
    logic [2:0]  pend;
    logic        stat_clr;

    assign stat_clr = wr & hit_stat & lane0;

    tic_edge_sticky #(
        .WIDTH (tic_pkg::NUM_CHAN)
    ) u_sticky (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .timer_out (timer_out),
        .clr_en    (stat_clr),
        .clr_bits  (pwdata[2:0]),
        .pending   (pend)
    );

    // ************************************************************
    // summary interrupt mask (separate from the channel masks)
    // ************************************************************
    logic [2:0]  imask_q;
    logic [2:0]  imask_d;

    assign imask_d = (wr & hit_msk & lane0) ? pwdata[2:0] : imask_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            imask_q <= tic_pkg::SIRQ_MASK_RST;
        else
            imask_q <= imask_d;
    end

    // ************************************************************
    // request routing
    // ************************************************************
    logic        req_d;
    logic        req_q;
    logic        irq_q;
    logic [3:0]  num_q;

    // registered so the serializer sees a glitch-free level
    assign req_d = en_q & |(pend & mask_q);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            req_q <= tic_pkg::REQ_RESET;
            irq_q <= tic_pkg::REQ_RESET;
            num_q <= tic_pkg::NUM_RESET;
        end
        else
        begin
            req_q <= req_d;
            irq_q <= |(pend & imask_q);
            num_q <= tic_pkg::IRQ_OF_SEL[sel_q];
        end
    end

    assign sirq_req = req_q;
    assign sirq_num = num_q;
    assign sirq_sel = sel_q;
    assign irq      = irq_q;

    // ************************************************************
    // read data
    // ************************************************************
    logic [31:0] rd_d;
    logic [31:0] rd_q;

    // upper bits of every register read as zero
    assign rd_d = (hit_ctl)  ? {24'h0, ctl_rd} :
                  (hit_stat) ? {29'h0, pend} :
                  (hit_msk)  ? {29'h0, imask_q} :
                               32'h0;

    // captured at setup so prdata is valid in the access cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_q <= 32'h0;
        else if (psel & ~penable & ~pwrite)
            rd_q <= rd_d;
    end

    assign prdata = rd_q;

endmodule

// file: bench/tic_chk.sv
`timescale 1ns/10ps
module tic_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    // timers and requests
    input wire logic [2:0]  timer_out,
    input wire logic        sirq_req,
    input wire logic [3:0]  sirq_num,
    input wire logic [2:0]  sirq_sel,
    input wire logic        irq
);
    // access decode, a write without lane 0 changes nothing
    wire acc = psel && penable;
    wire rd_c = acc && !pwrite && paddr == tic_pkg::ADDR_CONTROL;
    wire wr_c = acc && pwrite && pstrb[0] && paddr == tic_pkg::ADDR_CONTROL;
    wire rd_s = acc && !pwrite && paddr == tic_pkg::ADDR_STATUS;
    wire wr_s = acc && pwrite && pstrb[0] && paddr == tic_pkg::ADDR_STATUS;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ****
    // steps of a pending capture
    // ****
    sequence rise0;
        !timer_out[0] ##1 timer_out[0];
    endsequence
    sequence seen0;
        rise0 ##2 rd_s;
    endsequence
    AST_RSV_CTL: assert property (rd_c |-> prdata[31:8] == 24'h0 && !prdata[3])
        else $error("reserved control bit read as one");
    AST_RSV_STAT: assert property (rd_s |-> prdata[31:3] == 29'h0)
        else $error("reserved status bit read as one");
    AST_SEL_WR: assert property (wr_c |=> sirq_sel == $past(pwdata[6:4]))
        else $error("selector not loaded");
    AST_NUM: assert property ($stable(sirq_sel)[*2]
        |-> sirq_num == tic_pkg::IRQ_OF_SEL[sirq_sel])
        else $error("irq number does not follow selector");
    AST_OFF: assert property (wr_c && (!pwdata[7] || pwdata[2:0] == 3'h0)
        |=> ##1 !sirq_req)
        else $error("request while disabled or masked");
    AST_CLR: assert property (wr_s && pwdata[2:0] == 3'h7 && $stable(timer_out)
        ##1 $stable(timer_out) |=> !irq)
        else $error("status not cleared by one");
    AST_RISE: assert property (seen0 |-> prdata[0])
        else $error("rise not captured");
endmodule
bind tic_top tic_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata),
    .timer_out(timer_out), .sirq_req(sirq_req), .sirq_num(sirq_num), .sirq_sel(sirq_sel),
    .irq(irq));

// file: bench/tic_sirq_host.sv
`timescale 1ns/10ps
module tic_sirq_host (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // request from the device
    input  wire logic        sirq_req,
    input  wire logic [3:0]  sirq_num,
    // legacy irq lines seen by the host
    output logic      [15:0] irq_lines
);
    // serial framing not modelled, one cycle stands in for a frame
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            irq_lines <= 16'h0;
        else
            irq_lines <= sirq_req ? (16'h1 << sirq_num) : 16'h0;
    end
endmodule

// file: bench/timer_interrupt_control_status_tb.sv
`timescale 1ns/10ps
module timer_interrupt_control_status_tb;
    logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, sirq_req, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  sirq_num, pstrb;
    logic [2:0]  timer_out, sirq_sel;
    logic [15:0] irq_lines;
    logic [3:0]  num_tab [8] = '{4'h3, 4'h4, 4'h5, 4'ha, 4'h6, 4'h7, 4'h9, 4'hb};
    int          error_cnt = 0;
    int          cmp_count = 0;
    // ****
    // clock, device and host
    // ****
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    tic_top DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_out(timer_out), .sirq_req(sirq_req),
        .sirq_num(sirq_num), .sirq_sel(sirq_sel), .irq(irq));
    tic_sirq_host u_host (.clk_sys(clk_sys), .resetn(resetn), .sirq_req(sirq_req),
        .sirq_num(sirq_num), .irq_lines(irq_lines));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, idle cycle after so strobes never toggle twice in a step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {resetn, psel, penable, pwrite, paddr, pwdata, timer_out} = '0;
        pstrb = 4'hf;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
        xfer(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
        xfer(1'b1, 8'h00, 32'hffffffff); xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'hf7);
        // every selector code, enable off
        for (int s = 0; s < 8; s++)
        begin
            xfer(1'b1, 8'h00, {25'h0, s[2:0], 4'h0});
            repeat (2) @(posedge clk_sys);
            chk({sirq_sel, sirq_num}, {s[2:0], num_tab[s]});
        end
        // each channel: rise, ignore zeros and reserved ones, clear by one
        for (int i = 0; i < 3; i++)
        begin
            timer_out <= 3'h1 << i;
            @(posedge clk_sys);
            xfer(1'b0, 8'h04, 32'h0); chk(rd, 32'h1 << i);
            timer_out <= 3'h0;
            chk(irq, 1'b1);
            xfer(1'b1, 8'h04, 32'hf8); xfer(1'b0, 8'h04, 32'h0); chk(rd, 32'h1 << i);
            xfer(1'b1, 8'h04, 32'h1 << i); xfer(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
        end
        timer_out <= 3'h2;
        @(posedge clk_sys);
        timer_out <= 3'h0;
        xfer(1'b1, 8'h00, 32'ha2); repeat (3) @(posedge clk_sys); chk(irq_lines, 16'h20);
        chk(sirq_req, 1'b1);
        xfer(1'b1, 8'h00, 32'ha5); repeat (3) @(posedge clk_sys); chk(irq_lines, 16'h0);
        xfer(1'b1, 8'h00, 32'h22); repeat (3) @(posedge clk_sys); chk(irq_lines, 16'h0);
        chk(sirq_req, 1'b0);
        // a write without lane 0 must leave the control register alone
        pstrb <= 4'he;
        xfer(1'b1, 8'h00, 32'hff);
        pstrb <= 4'hf;
        xfer(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h22);
        xfer(1'b1, 8'h08, 32'h0); repeat (2) @(posedge clk_sys); chk(irq, 1'b0);
        xfer(1'b1, 8'h08, 32'h7); repeat (2) @(posedge clk_sys); chk(irq, 1'b1);
        xfer(1'b1, 8'h04, 32'h7); repeat (2) @(posedge clk_sys); chk(irq, 1'b0);
        xfer(1'b0, 8'h0c, 32'h0); chk({err, rd}, {1'b1, 32'h0});
        conclude();
    end
    // watchdog, the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
endmodule
